// ===== mpc_motor_pwm_counter.v
// Behaviour
// RQ1: counter, period and duty are all ten bits wide.
// RQ2: period assembled from low byte bits 7..0 and high byte bits 9..8.
// RQ3: three independent ten-bit duty values, one per channel.
// RQ4: running count readable via read-only low and high bytes.
// RQ5: run bit set counts; cleared stops counter and turns outputs off.
// RQ6: alignment 0x edge, 10 centre mode 1, 11 centre mode 2.
// RQ7: clock select divides base clock by 1, 2, 4 or 8.
// RQ8: 20 MHz base gives 20 kHz minimum, halving per divide step.
// RQ9: duty interrupt field: off, up only, down only, both.
// RQ10: reload bit zero keeps written values out of working registers.
// RQ11: reload set loads at next underflow, bit clears next cycle.
// RQ12: software writes high byte before low byte.
// RQ13: high bytes bits 7..2 read as zero.
// RQ14: count bits 9..8 in low bits of count high, reset zero.
// RQ15: edge counts up and restarts; centre counts up and down; out while count < duty.
// RQ16: duty interrupt when count equals duty in enabled direction; here raised only in the centre modes.
//
// Purpose: three channel ten-bit motor pwm counter with avalon register slave
// Assumes: single core_clk domain, synchronous active-high rst
// Notes: working registers take staged values only through the reload bit
//
// Chosen here: the Avalon-MM register port and the register offsets.
`default_nettype none
`include "mpc_consts.vh"
module mpc_motor_pwm_counter #(
	parameter WIDTH = 10,
	parameter CHANNELS = 3
)
(
	input wire core_clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output reg [CHANNELS-1:0] modulated_output,
	output reg duty_event,
	output reg underflow
);
	localparam BASE_DIV = `MPC_CORE_CLK_HZ / `MPC_BASE_CLK_HZ;
	// slowest frame at divide 1 is base/min = 1000 steps, matches the 10-bit range
	localparam MIN_STEPS = `MPC_BASE_CLK_HZ / `MPC_MIN_PWM_HZ; // RQ8

	reg [7:0] waveform_control;
	reg [WIDTH-1:0] period_stage;
	reg [WIDTH-1:0] duty_stage [0:CHANNELS-1];
	reg [WIDTH-1:0] period_work;
	reg [WIDTH-1:0] duty_work [0:CHANNELS-1];
	reg [WIDTH-1:0] count;
	reg count_down;
	reg ack;
	reg [CHANNELS-1:0] hit_sticky;
	reg [WIDTH-1:0] next_count;
	reg next_count_down;
	reg next_underflow;
	reg [31:0] next_readdata;
	reg [CHANNELS-1:0] duty_match;
	wire tick;
	wire run;
	wire [1:0] alignment_select;
	wire [1:0] counter_clock_select;
	wire [1:0] duty_interrupt_direction;
	wire reload_request;
	wire centre;
	wire at_top;
	wire at_bottom;
	wire wr;
	wire event_gate;
	wire status_clear;
	integer i;
	integer j;
	integer k;
	integer m;

	assign run = waveform_control[`MPC_CTL_RUN];
	assign alignment_select = waveform_control[`MPC_CTL_ALIGN_HI:`MPC_CTL_ALIGN_LO];
	assign counter_clock_select = waveform_control[`MPC_CTL_CLK_HI:`MPC_CTL_CLK_LO];
	assign duty_interrupt_direction = waveform_control[`MPC_CTL_IRQ_HI:`MPC_CTL_IRQ_LO];
	assign reload_request = waveform_control[`MPC_CTL_RELOAD];
	assign centre = alignment_select[1]; // RQ6
	assign at_top = (count >= period_work);
	assign at_bottom = (count == {WIDTH{1'b0}});
	// a write lands at the edge where waitrequest is seen low
	assign wr = avs_write && ack && avs_byteenable[0];
	// match reporting needs a tick in centre mode in an enabled direction
	assign event_gate = tick && centre &&
		((duty_interrupt_direction[`MPC_IRQ_UP] && !count_down) || // RQ9
		(duty_interrupt_direction[`MPC_IRQ_DOWN] && count_down)); // RQ9
	// the status read clears at its completing edge
	assign status_clear = avs_read && ack && (avs_address == `MPC_IDX_STATUS);

	// one wait state for every access, answer on the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	// byte field helpers used by the read decode
	function [7:0] mpc_low_byte;
		input [WIDTH-1:0] v;
		begin
			mpc_low_byte = v[7:0];
		end
	endfunction

	function [7:0] mpc_high_byte;
		input [WIDTH-1:0] v;
		begin
			mpc_high_byte = {6'h00, v[9:8]}; // RQ13
		end
	endfunction

	// byte merge helpers for the staged high-byte-first writes
	function [WIDTH-1:0] mpc_set_low;
		input [WIDTH-1:0] v;
		input [7:0] b;
		begin
			mpc_set_low = {v[WIDTH-1:8], b};
		end
	endfunction

	function [WIDTH-1:0] mpc_set_high;
		input [WIDTH-1:0] v;
		input [7:0] b;
		begin
			mpc_set_high = {b[1:0], v[7:0]};
		end
	endfunction

	// single counter steps shared by both counting directions
	function [WIDTH-1:0] mpc_inc;
		input [WIDTH-1:0] v;
		begin
			mpc_inc = v + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	endfunction

	function [WIDTH-1:0] mpc_dec;
		input [WIDTH-1:0] v;
		begin
			mpc_dec = v - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	endfunction

	mpc_prescaler #(
		.BASE_DIV(BASE_DIV)
	) u_prescaler (
		.core_clk(core_clk),
		.rst(rst),
		.run(run),
		.clock_select(counter_clock_select), // RQ7
		.tick(tick)
	);

	// bus acknowledge toggles so each access takes exactly two edges
	always @(posedge core_clk)
	begin
		if (rst)
			ack <= 1'b0;
		else
			ack <= (avs_read || avs_write) && !ack;
	end

	// control register; hardware clear of reload on the same edge as the load
	always @(posedge core_clk)
	begin
		if (rst)
			waveform_control <= `MPC_CTL_RESET;
		else
		begin
			// a software write in the same cycle keeps its own reload bit
			if (wr && avs_address == `MPC_IDX_CONTROL)
				waveform_control <= avs_writedata[7:0];
			else if (underflow && reload_request)
				waveform_control[`MPC_CTL_RELOAD] <= 1'b0; // RQ11
		end
	end

	// staged period and duty; high byte expected first, low byte completes
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			period_stage <= {WIDTH{1'b0}};
			for (i = 0; i < CHANNELS; i = i + 1)
				duty_stage[i] <= {WIDTH{1'b0}};
		end
		else if (wr)
		begin
			case (avs_address)
				`MPC_IDX_PERIOD_LOW: period_stage <= mpc_set_low(period_stage, avs_writedata[7:0]); // RQ2
				`MPC_IDX_PERIOD_HIGH: period_stage <= mpc_set_high(period_stage, avs_writedata[7:0]); // RQ2
				`MPC_IDX_DUTY0_LOW: duty_stage[0] <= mpc_set_low(duty_stage[0], avs_writedata[7:0]); // RQ3
				`MPC_IDX_DUTY0_HIGH: duty_stage[0] <= mpc_set_high(duty_stage[0], avs_writedata[7:0]); // RQ3
				`MPC_IDX_DUTY1_LOW: duty_stage[1] <= mpc_set_low(duty_stage[1], avs_writedata[7:0]); // RQ3
				`MPC_IDX_DUTY1_HIGH: duty_stage[1] <= mpc_set_high(duty_stage[1], avs_writedata[7:0]); // RQ3
				`MPC_IDX_DUTY2_LOW: duty_stage[2] <= mpc_set_low(duty_stage[2], avs_writedata[7:0]); // RQ3
				`MPC_IDX_DUTY2_HIGH: duty_stage[2] <= mpc_set_high(duty_stage[2], avs_writedata[7:0]); // RQ3
				default: ;
			endcase
		end
	end

	// next count: edge counts up and wraps, centre counts up then down
	always @*
	begin
		next_count = count;
		next_count_down = count_down;
		next_underflow = 1'b0;
		if (tick)
		begin
			if (!centre)
			begin
				next_count_down = 1'b0;
				if (at_top)
				begin
					next_count = {WIDTH{1'b0}}; // RQ15
					next_underflow = 1'b1;
				end
				else
					next_count = mpc_inc(count); // RQ1
			end
			else if (!count_down)
			begin
				if (at_top && at_bottom)
				begin
					// a zero period would otherwise wrap the count down to all ones
					next_underflow = 1'b1;
				end
				else if (at_top)
				begin
					next_count_down = 1'b1; // RQ15
					next_count = mpc_dec(count);
				end
				else
					next_count = mpc_inc(count);
			end
			else
			begin
				if (at_bottom || count == {{(WIDTH-1){1'b0}}, 1'b1})
				begin
					// turn point at zero marks the underflow
					next_count = {WIDTH{1'b0}};
					next_count_down = 1'b0;
					next_underflow = 1'b1;
				end
				else
					next_count = mpc_dec(count);
			end
		end
	end

	// counter registers; a stopped counter is held at zero
	always @(posedge core_clk)
	begin
		if (rst || !run)
		begin
			count <= {WIDTH{1'b0}}; // RQ5
			count_down <= 1'b0;
			underflow <= 1'b0;
		end
		else
		begin
			count <= next_count;
			count_down <= next_count_down;
			underflow <= next_underflow;
		end
	end

	// working registers load only on underflow with reload set
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			period_work <= {WIDTH{1'b0}};
			for (j = 0; j < CHANNELS; j = j + 1)
				duty_work[j] <= {WIDTH{1'b0}};
		end
		else if (underflow && reload_request) // RQ10 RQ11
		begin
			period_work <= period_stage;
			for (j = 0; j < CHANNELS; j = j + 1)
				duty_work[j] <= duty_stage[j];
		end
	end

	// outputs high while count below duty; forced low when stopped
	always @(posedge core_clk)
	begin
		if (rst || !run)
			modulated_output <= {CHANNELS{1'b0}}; // RQ5
		else
			for (k = 0; k < CHANNELS; k = k + 1)
				modulated_output[k] <= (count < duty_work[k]); // RQ15
	end

	// per-channel equality against the working duty
	always @*
	begin
		duty_match = {CHANNELS{1'b0}};
		for (m = 0; m < CHANNELS; m = m + 1)
			duty_match[m] = (count == duty_work[m]); // RQ16
	end

	// duty match pulse in centre modes, gated by the direction field
	always @(posedge core_clk)
	begin
		if (rst || !run)
		begin
			duty_event <= 1'b0;
			hit_sticky <= {CHANNELS{1'b0}};
		end
		else
		begin
			// a match is reported once per tick, not on every core cycle
			duty_event <= event_gate && (|duty_match);
			// read clear first, so a hit in the same cycle wins per bit
			hit_sticky <= (status_clear ? {CHANNELS{1'b0}} : hit_sticky) |
				(event_gate ? duty_match : {CHANNELS{1'b0}});
		end
	end

	// register read mux; unmapped indices read as zero
	always @*
	begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`MPC_IDX_CONTROL: next_readdata = {24'h00_0000, waveform_control};
			`MPC_IDX_DUTY0_LOW: next_readdata = {24'h00_0000, mpc_low_byte(duty_stage[0])};
			`MPC_IDX_DUTY0_HIGH: next_readdata = {24'h00_0000, mpc_high_byte(duty_stage[0])};
			`MPC_IDX_DUTY1_LOW: next_readdata = {24'h00_0000, mpc_low_byte(duty_stage[1])};
			`MPC_IDX_DUTY1_HIGH: next_readdata = {24'h00_0000, mpc_high_byte(duty_stage[1])};
			`MPC_IDX_DUTY2_LOW: next_readdata = {24'h00_0000, mpc_low_byte(duty_stage[2])};
			`MPC_IDX_DUTY2_HIGH: next_readdata = {24'h00_0000, mpc_high_byte(duty_stage[2])};
			`MPC_IDX_PERIOD_LOW: next_readdata = {24'h00_0000, mpc_low_byte(period_stage)};
			`MPC_IDX_PERIOD_HIGH: next_readdata = {24'h00_0000, mpc_high_byte(period_stage)};
			`MPC_IDX_COUNT_LOW: next_readdata = {24'h00_0000, mpc_low_byte(count)}; // RQ4
			`MPC_IDX_COUNT_HIGH: next_readdata = {24'h00_0000, mpc_high_byte(count)}; // RQ14
			`MPC_IDX_STATUS: next_readdata = {29'h0000_0000, hit_sticky};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// read data registered on the first cycle, stands at the acknowledge edge
	always @(posedge core_clk)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack)
			avs_readdata <= next_readdata;
	end
endmodule
`default_nettype wire

// ===== mpc_consts.vh
// Purpose: constants for the motor pwm counter
// Assumes: included by bare name from the design files
// Notes: register indices are word indices on the avalon bus
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH
`define MPC_IDX_CONTROL 4'h0
`define MPC_IDX_DUTY0_LOW 4'h1
`define MPC_IDX_DUTY0_HIGH 4'h2
`define MPC_IDX_DUTY1_LOW 4'h3
`define MPC_IDX_DUTY1_HIGH 4'h4
`define MPC_IDX_DUTY2_LOW 4'h5
`define MPC_IDX_DUTY2_HIGH 4'h6
`define MPC_IDX_PERIOD_LOW 4'h7
`define MPC_IDX_PERIOD_HIGH 4'h8
`define MPC_IDX_COUNT_LOW 4'h9
`define MPC_IDX_COUNT_HIGH 4'hA
`define MPC_IDX_STATUS 4'hB
`define MPC_CTL_RESET 8'h00
`define MPC_CTL_RELOAD 0
`define MPC_CTL_IRQ_LO 1
`define MPC_CTL_IRQ_HI 2
`define MPC_CTL_RUN 3
`define MPC_CTL_CLK_LO 4
`define MPC_CTL_CLK_HI 5
`define MPC_CTL_ALIGN_LO 6
`define MPC_CTL_ALIGN_HI 7
`define MPC_ALIGN_CENTRE1 2'b10
`define MPC_ALIGN_CENTRE2 2'b11
`define MPC_IRQ_UP 0
`define MPC_IRQ_DOWN 1
`define MPC_BASE_CLK_HZ 20000000
`define MPC_CORE_CLK_HZ 200000000
`define MPC_MIN_PWM_HZ 20000
`endif

// ===== mpc_prescaler.v
// Purpose: counter clock tick generator, base tick divided by 1, 2, 4 or 8
// Assumes: core_clk 200 MHz, base tick derived from the 20 MHz pwm clock
// Notes: one tick pulse per counter step
`default_nettype none
module mpc_prescaler #(
	parameter BASE_DIV = 10
)
(
	input wire core_clk,
	input wire rst,
	input wire run,
	input wire [1:0] clock_select,
	output reg tick
);
	reg [7:0] base_cnt;
	reg [2:0] div_cnt;
	wire base_tick;
	wire [2:0] div_mask;

	// base tick at the pwm base rate
	assign base_tick = (base_cnt == BASE_DIV[7:0] - 8'h01);
	// divide 1,2,4,8 by masking a free counter
	assign div_mask = (3'b001 << clock_select) - 3'b001;

	// counters stop with the run bit so no stray tick starts a frame early
	always @(posedge core_clk)
	begin
		if (rst || !run)
		begin
			base_cnt <= 8'h00;
			div_cnt <= 3'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (base_tick)
			begin
				base_cnt <= 8'h00;
				div_cnt <= div_cnt + 3'h1;
				tick <= ((div_cnt & div_mask) == 3'h0);
			end
			else
				base_cnt <= base_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== mpc_chk.sv
// Purpose: port checker for the pwm counter
// Assumes: one clock, sync active-high rst
// Notes: ctl mirrors the last control write seen on the bus
`default_nettype none
module mpc_chk #(
	parameter CHANNELS = 3
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [CHANNELS-1:0] modulated_output,
	input wire logic duty_event,
	input wire logic underflow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	wire logic rd_done = avs_read && !avs_waitrequest;
	wire logic irq_on = ctl[7] && ctl[2:1] != 2'b00;
	// control mirror; the reload self-clear does not matter to these checks
	always_ff @(posedge core_clk)
	begin
		if (rst)
			ctl <= 8'h00;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0])
			ctl <= avs_writedata[7:0];
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	chk_idle_free: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("wait while idle");
	chk_rd_upper: assert property (rd_done |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	chk_high_zero: assert property (rd_done && !avs_address[0] && avs_address != 4'h0 |-> avs_readdata[7:2] == 6'h00)
		else $error("high byte spare bits set");
	chk_unmapped: assert property (rd_done && avs_address > 4'hB |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_uf_spaced: assert property (underflow |=> !underflow [*8])
		else $error("underflow pulses too close");
	chk_off_quiet: assert property (!ctl[3] && !$past(ctl[3]) |-> modulated_output == '0 && !duty_event)
		else $error("activity while stopped");
	chk_irq_mode: assert property (duty_event |-> irq_on || $past(irq_on))
		else $error("duty event not enabled");
endmodule
`default_nettype wire

// ===== mpc_gate_model.sv
// Purpose: gate driver side model, measures each pwm frame
// Assumes: frames are bounded by underflow pulses
// Notes: counts are latched at the closing underflow of each frame
`default_nettype none
module mpc_gate_model (
	input wire logic core_clk,
	input wire logic [2:0] modulated_output,
	input wire logic underflow,
	input wire logic duty_event,
	output logic [11:0] frame_len,
	output logic [35:0] hi,
	output logic [3:0] ev_cnt,
	output logic [7:0] frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0] acc = '0;
	logic [11:0] acc_len = '0;
	logic [3:0] acc_ev = '0;
	initial frames = 8'h00;
	// per-frame high time, length and event count
	always @(posedge core_clk)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (underflow)
				hi[i*12 +: 12] <= acc[i*12 +: 12] + 12'(modulated_output[i]);
			acc[i*12 +: 12] <= underflow ? 12'h000 : acc[i*12 +: 12] + 12'(modulated_output[i]);
		end
		if (underflow)
		begin
			frame_len <= acc_len + 12'h001;
			ev_cnt <= acc_ev + 4'(duty_event);
			frames <= frames + 8'h01;
		end
		acc_len <= underflow ? 12'h000 : acc_len + 12'h001;
		acc_ev <= underflow ? 4'h0 : acc_ev + 4'(duty_event);
	end
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the pwm counter
// Assumes: 200 MHz core_clk, bus slave answers after its wait state
// Notes: period 4 keeps an edge frame at 50 core cycles
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, duty_event, underflow;
	logic [2:0] mo;
	logic [11:0] frame_len;
	logic [35:0] hi;
	logic [3:0] ev_cnt;
	logic [7:0] frames;
	int mismatches = 0;
	int checks_done = 0;
	mpc_motor_pwm_counter u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.modulated_output(mo), .duty_event(duty_event), .underflow(underflow));
	mpc_gate_model u_gate (.core_clk(core_clk), .modulated_output(mo), .underflow(underflow),
		.duty_event(duty_event), .frame_len(frame_len), .hi(hi), .ev_cnt(ev_cnt), .frames(frames));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one bus access; a spare edge keeps the next request off this edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge core_clk);
			n++;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
		if (n >= 50)
			mismatches++;
	endtask
	task automatic frames_wait(input int k);
		int n;
		logic [7:0] f0;
		n = 0;
		f0 = frames;
		while (frames - f0 < k && n < 2000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 2000)
			mismatches++;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 13; a++)
		begin
			bus(1'b0, 4'(a), 8'h00);
			cmp(rd, 36'h0);
		end
	endtask
	task automatic t_stage;
		bus(1'b1, 4'h8, 8'hFC);
		bus(1'b1, 4'h7, 8'h04);
		bus(1'b1, 4'h6, 8'hFD);
		bus(1'b1, 4'h5, 8'h05);
		bus(1'b1, 4'h3, 8'h01);
		bus(1'b1, 4'h1, 8'h02);
		avs_byteenable <= 4'h0;
		bus(1'b1, 4'h1, 8'h33);
		avs_byteenable <= 4'hF;
		bus(1'b1, 4'hC, 8'h55);
		bus(1'b0, 4'hC, 8'h00);
		cmp(rd, 36'h0);
		bus(1'b0, 4'h8, 8'h00);
		cmp(rd, 36'h0);
		bus(1'b0, 4'h6, 8'h00);
		cmp(rd, 36'h1);
		bus(1'b0, 4'h1, 8'h00);
		cmp(rd, 36'h2);
	endtask
	task automatic t_edge;
		bus(1'b1, 4'h0, 8'h09);
		frames_wait(1);
		bus(1'b0, 4'h0, 8'h00);
		cmp(rd, 36'h8);
		frames_wait(2);
		cmp(frame_len, 36'h32);
		cmp(hi, {12'h032, 12'h00A, 12'h014});
		bus(1'b0, 4'h9, 8'h00);
		cmp(rd[7:0] <= 8'h04, 1'b1);
		bus(1'b1, 4'h2, 8'h00);
		bus(1'b1, 4'h1, 8'h03);
		frames_wait(2);
		cmp(hi[11:0], 12'h014);
		bus(1'b1, 4'h0, 8'h09);
		frames_wait(3);
		cmp(hi[11:0], 12'h01E);
	endtask
	// frame doubles per prescale step, so the lowest rate halves
	task automatic t_clk;
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, 4'h0, {2'b00, 2'(s), 4'h8});
			frames_wait(2);
			cmp(frame_len, 36'h32 << s);
		end
	endtask
	task automatic t_centre;
		for (int m = 2; m < 4; m++)
			for (int d = 0; d < 4; d++)
			begin
				bus(1'b1, 4'h0, {2'(m), 3'b001, 2'(d), 1'b0});
				frames_wait(2);
				cmp(frame_len, 36'h50);
				cmp(hi, {12'h050, 12'h00A, 12'h032});
				cmp(ev_cnt, 2 * (d % 2 + d / 2));
			end
		// matches stay latched once the direction field turns reporting off
		bus(1'b1, 4'h0, 8'hC8);
		frames_wait(1);
		bus(1'b0, 4'hB, 8'h00);
		cmp(rd, 36'h3);
		bus(1'b0, 4'hB, 8'h00);
		cmp(rd, 36'h0);
	endtask
	task automatic t_stop;
		bus(1'b1, 4'h0, 8'h00);
		repeat (3) @(posedge core_clk);
		cmp(mo, 3'h0);
		bus(1'b0, 4'h9, 8'h00);
		cmp(rd, 36'h0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		close_out();
	end
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_stage();
		t_edge();
		t_clk();
		t_centre();
		t_stop();
		close_out();
	end
endmodule
bind mpc_motor_pwm_counter mpc_chk #(.CHANNELS(CHANNELS)) u_chk (.core_clk(core_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.modulated_output(modulated_output), .duty_event(duty_event), .underflow(underflow));
`default_nettype wire
